//--- compat_mode_decode_unit.sv
// Compatibility-mode decode unit: fetch, classify, address and execute clear/decrement.
// Assumes the memory path holds mem_rdata valid with mem_ack; byte reads return the byte in bits 7:0.
module compat_mode_decode_unit (
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire logic                 run,
    output compat_pkg::mem_cmd_t      mem_cmd,
    input  wire logic                 mem_ack,
    input  wire logic [15:0]          mem_rdata,
    output logic                      class_exec,
    output logic                      class_trap,
    output logic                      class_rsvd,
    output compat_pkg::decode_t       decode_info,
    output logic                      exec_other,
    input  wire logic                 ext_done,
    output logic                      fault,
    output logic                      fault_is_trap,
    output logic [15:0]               fault_instr,
    input  wire logic                 fault_ack,
    input  wire logic                 status_load,
    input  wire logic [4:0]           status_in,
    output logic [15:0]               compat_status_word,
    input  wire logic                 reg_wr,
    input  wire logic [2:0]           reg_idx,
    input  wire logic [15:0]          reg_wdata,
    output logic [15:0]               reg_rdata,
    output logic                      busy
);
    import compat_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE, S_FETCH, S_DECODE, S_REGOP, S_INDEX, S_PTR,
        S_OPRD, S_WRITE, S_POP_PC, S_POP_PS, S_HANDOFF, S_FAULT
    } state_t;

    state_t      state_ff,  nxt_state;
    logic [15:0] regs_ff [8];
    logic [15:0] nxt_regs [8];
    logic [4:0]  status_ff, nxt_status;
    logic [15:0] ir_ff,     nxt_ir;
    logic [15:0] addr_ff,   nxt_addr;
    logic [15:0] res_ff,    nxt_res;
    logic [2:0]  pflag_ff,  nxt_pflag;
    logic        fault_ff,  nxt_fault;
    logic        trap_ff,   nxt_trap;
    logic [15:0] rd_ff,     nxt_rd;

    decode_t     dinfo;
    logic [2:0]  mode;
    logic [2:0]  rn;
    logic [15:0] rv;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] step;
    logic [15:0] base;
    logic [15:0] opnd;
    logic [15:0] r16;
    logic [7:0]  r8;
    logic        n16, z16, v16;
    logic        n8,  z8,  v8;
    logic        is_zero;

    opcode_classifier u_cls (
        .instr (ir_ff),
        .info  (dinfo)
    );

    // Word and byte views of the same operand, picked by the byte flag
    flag_alu #(.W(16)) u_alu16 (
        .opnd   (opnd),
        .clear  (is_zero),
        .result (r16),
        .neg    (n16),
        .zero   (z16),
        .ovf    (v16)
    );

    flag_alu #(.W(8)) u_alu8 (
        .opnd   (opnd[7:0]),
        .clear  (is_zero),
        .result (r8),
        .neg    (n8),
        .zero   (z8),
        .ovf    (v8)
    );

    // Operand fields and register views
    assign mode    = dinfo.spec[5:3];
    assign rn      = dinfo.spec[2:0];
    assign rv      = regs_ff[rn];
    assign pc      = regs_ff[PC_IDX];
    assign sp      = regs_ff[SP_IDX];
    assign is_zero = (dinfo.op == OP_ZERO);
    assign opnd    = (state_ff == S_REGOP) ? rv : mem_rdata;
    // Stack pointer and program counter always move by a whole word
    assign step    = (dinfo.is_byte && rn < SP_IDX) ? BYTE_STEP : WORD_STEP;
    assign base    = (rn == PC_IDX) ? pc + WORD_STEP : rv;

    // Memory command built from state and registered address and data
    always_comb begin
        mem_cmd.req      = state_ff inside {S_FETCH, S_INDEX, S_PTR, S_OPRD, S_WRITE, S_POP_PC, S_POP_PS};
        mem_cmd.we       = (state_ff == S_WRITE);
        mem_cmd.byte_acc = dinfo.is_byte && (state_ff inside {S_OPRD, S_WRITE});
        mem_cmd.addr     = addr_ff;
        mem_cmd.wdata    = res_ff;
    end

    // Class strobes during decode, and the hand-off outputs
    assign class_exec         = (state_ff == S_DECODE) && (dinfo.cls == CLS_EXEC);
    assign class_trap         = (state_ff == S_DECODE) && (dinfo.cls == CLS_TRAP);
    assign class_rsvd         = (state_ff == S_DECODE) && (dinfo.cls == CLS_RSVD);
    assign decode_info        = dinfo;
    assign exec_other         = (state_ff == S_HANDOFF);
    assign fault              = fault_ff;
    assign fault_is_trap      = trap_ff;
    assign fault_instr        = ir_ff;
    assign compat_status_word = {STATUS_PAD, status_ff};
    assign reg_rdata          = rd_ff;
    assign busy               = (state_ff != S_IDLE);

    // Sequencer next-state and datapath updates
    always_comb begin
        nxt_state  = state_ff;
        nxt_regs   = regs_ff;
        nxt_status = status_ff;
        nxt_ir     = ir_ff;
        nxt_addr   = addr_ff;
        nxt_res    = res_ff;
        nxt_pflag  = pflag_ff;
        nxt_fault  = fault_ff;
        nxt_trap   = trap_ff;
        nxt_rd     = regs_ff[reg_idx];
        unique case (state_ff)
            S_IDLE: begin
                // Loading is only safe while stopped, so it is taken only with run low
                if (!run && reg_wr) nxt_regs[reg_idx] = reg_wdata;
                if (!run && status_load) nxt_status = status_in;
                if (run) begin
                    nxt_state = S_FETCH;
                    nxt_addr  = pc;
                end
            end
            S_FETCH: if (mem_ack) begin
                nxt_ir           = mem_rdata;
                nxt_regs[PC_IDX] = pc + WORD_STEP;
                nxt_state        = S_DECODE;
            end
            S_DECODE: begin
                unique case (dinfo.cls)
                    CLS_TRAP, CLS_RSVD: begin
                        // No exception frame is pushed; the native core takes over
                        nxt_fault = 1'b1;
                        nxt_trap  = (dinfo.cls == CLS_TRAP);
                        nxt_state = S_FAULT;
                    end
                    CLS_EXEC: begin
                        unique case (dinfo.op)
                            OP_IRET: begin
                                nxt_addr  = sp;
                                nxt_state = S_POP_PC;
                            end
                            OP_OTHER: nxt_state = S_HANDOFF;
                            OP_ZERO, OP_MINUS: begin
                                unique case (mode)
                                    M_REG: nxt_state = S_REGOP;
                                    M_DEF: begin
                                        nxt_addr  = rv;
                                        nxt_state = S_OPRD;
                                    end
                                    M_AINC: begin
                                        nxt_addr     = rv;
                                        nxt_regs[rn] = rv + step;
                                        nxt_state    = S_OPRD;
                                    end
                                    M_AINCD: begin
                                        nxt_addr     = rv;
                                        nxt_regs[rn] = rv + WORD_STEP;
                                        nxt_state    = S_PTR;
                                    end
                                    M_ADEC: begin
                                        nxt_addr     = rv - step;
                                        nxt_regs[rn] = rv - step;
                                        nxt_state    = S_OPRD;
                                    end
                                    M_ADECD: begin
                                        nxt_addr     = rv - WORD_STEP;
                                        nxt_regs[rn] = rv - WORD_STEP;
                                        nxt_state    = S_PTR;
                                    end
                                    M_IDX, M_IDXD: begin
                                        nxt_addr  = pc;
                                        nxt_state = S_INDEX;
                                    end
                                endcase
                            end
                        endcase
                    end
                endcase
            end
            S_REGOP: begin
                nxt_regs[rn] = dinfo.is_byte ? {rv[15:8], r8} : r16;
                nxt_status[ST_N] = dinfo.is_byte ? n8 : n16;
                nxt_status[ST_Z] = dinfo.is_byte ? z8 : z16;
                nxt_status[ST_V] = dinfo.is_byte ? v8 : v16;
                if (is_zero) nxt_status[ST_C] = 1'b0;
                nxt_state = S_IDLE;
            end
            S_INDEX: if (mem_ack) begin
                nxt_regs[PC_IDX] = pc + WORD_STEP;
                nxt_addr         = base + mem_rdata;
                nxt_state        = (mode == M_IDX) ? S_OPRD : S_PTR;
            end
            S_PTR: if (mem_ack) begin
                nxt_addr  = mem_rdata;
                nxt_state = S_OPRD;
            end
            S_OPRD: if (mem_ack) begin
                nxt_res   = dinfo.is_byte ? {8'h00, r8} : r16;
                nxt_pflag = dinfo.is_byte ? {n8, z8, v8} : {n16, z16, v16};
                nxt_state = S_WRITE;
            end
            S_WRITE: if (mem_ack) begin
                nxt_status[ST_N] = pflag_ff[PF_N];
                nxt_status[ST_Z] = pflag_ff[PF_Z];
                nxt_status[ST_V] = pflag_ff[PF_V];
                if (is_zero) nxt_status[ST_C] = 1'b0;
                nxt_state = S_IDLE;
            end
            S_POP_PC: if (mem_ack) begin
                nxt_regs[PC_IDX] = mem_rdata;
                nxt_regs[SP_IDX] = sp + WORD_STEP;
                nxt_addr         = sp + WORD_STEP;
                nxt_state        = S_POP_PS;
            end
            S_POP_PS: if (mem_ack) begin
                nxt_status       = mem_rdata[4:0];
                nxt_regs[SP_IDX] = sp + WORD_STEP;
                nxt_state        = S_IDLE;
            end
            S_HANDOFF: if (ext_done) nxt_state = S_IDLE;
            S_FAULT: if (fault_ack) begin
                nxt_fault = 1'b0;
                nxt_state = S_IDLE;
            end
        endcase
        // Clear never needs the old operand, so its read is skipped
        if (nxt_state == S_OPRD && state_ff != S_OPRD && is_zero) begin
            nxt_state = S_WRITE;
            nxt_res   = '0;
            nxt_pflag = ZERO_PFLAGS;
        end
    end

    // Register all sequencer state
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_ff  <= S_IDLE;
            for (int i = 0; i < 8; i++) regs_ff[i] <= REG_RESET;
            status_ff <= STATUS_RESET;
            ir_ff     <= REG_RESET;
            addr_ff   <= REG_RESET;
            res_ff    <= REG_RESET;
            pflag_ff  <= 3'h0;
            fault_ff  <= 1'b0;
            trap_ff   <= 1'b0;
            rd_ff     <= REG_RESET;
        end else begin
            state_ff  <= nxt_state;
            regs_ff   <= nxt_regs;
            status_ff <= nxt_status;
            ir_ff     <= nxt_ir;
            addr_ff   <= nxt_addr;
            res_ff    <= nxt_res;
            pflag_ff  <= nxt_pflag;
            fault_ff  <= nxt_fault;
            trap_ff   <= nxt_trap;
            rd_ff     <= nxt_rd;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_minus_mode(logic [2:0] m);
        state_ff == S_DECODE && dinfo.cls == CLS_EXEC && dinfo.op == OP_MINUS && mode == m;
    endsequence
    sequence s_write_done(op_t o);
        state_ff == S_WRITE && mem_ack && dinfo.op == o;
    endsequence

    chk_autodec_ptr: assert property (s_minus_mode(M_ADECD) |=> state_ff == S_PTR && addr_ff == $past(rv) - WORD_STEP)
        else $error("autodecrement deferred address wrong");
    chk_ptr_to_ea: assert property (state_ff == S_PTR && mem_ack |=> addr_ff == $past(mem_rdata) && state_ff != S_PTR)
        else $error("pointer word not used as operand address");
    chk_index_sum: assert property (state_ff == S_INDEX && mem_ack && rn != PC_IDX |=> addr_ff == $past(rv) + $past(mem_rdata))
        else $error("index sum wrong");
    chk_rel_base: assert property (state_ff == S_INDEX && mem_ack && rn == PC_IDX
                                   |=> addr_ff == $past(pc) + WORD_STEP + $past(mem_rdata))
        else $error("relative base not the advanced counter");
    chk_no_stack_push: assert property (state_ff == S_DECODE && dinfo.cls != CLS_EXEC |=> $stable(regs_ff[SP_IDX]) [*2])
        else $error("stack pointer moved on fault");
    chk_status_high: assert property (compat_status_word[15:5] == STATUS_PAD)
        else $error("status upper bits not zero");
    chk_iret_mask: assert property (state_ff == S_POP_PS && mem_ack |=> status_ff == $past(mem_rdata[4:0]) && state_ff == S_IDLE)
        else $error("popped status not masked");
    chk_byte_width: assert property (state_ff == S_DECODE && ir_ff[14:9] == 6'h05 |-> dinfo.is_byte == ir_ff[15])
        else $error("width digit misdecoded");
    chk_class_onehot: assert property (state_ff == S_DECODE |-> $onehot({class_exec, class_trap, class_rsvd}))
        else $error("class outputs not one-hot");
    chk_trap_fault: assert property (class_trap |=> fault && fault_is_trap && state_ff == S_FAULT)
        else $error("trap did not fault");
    chk_fp_reserved: assert property (state_ff == S_DECODE && ir_ff[15:12] == 4'hf |-> class_rsvd ##1 fault && !fault_is_trap)
        else $error("floating point not reserved");
    chk_zero_flags: assert property (s_write_done(OP_ZERO) |=> status_ff[3:0] == ZERO_NZVC)
        else $error("clear flags wrong");
    chk_minus_carry: assert property (s_write_done(OP_MINUS) |=> $stable(status_ff[ST_C]))
        else $error("decrement touched carry");
    chk_minus_wrap: assert property (state_ff == S_OPRD && mem_ack && dinfo.op == OP_MINUS && !dinfo.is_byte
                                   && mem_rdata == 16'h8000 |=> res_ff == 16'h7fff && pflag_ff[PF_V])
        else $error("decrement overflow wrong");
endmodule

//--- compat_pkg.sv
// Constants and types shared by the compatibility-mode decode unit.
// Assumes one clock domain and a 16-bit operand memory path with a req/ack handshake.
package compat_pkg;
    localparam logic [2:0]  SP_IDX       = 3'h6;
    localparam logic [2:0]  PC_IDX       = 3'h7;
    localparam logic [15:0] WORD_STEP    = 16'h0002;
    localparam logic [15:0] BYTE_STEP    = 16'h0001;
    localparam logic [15:0] REG_RESET    = 16'h0000;
    localparam logic [4:0]  STATUS_RESET = 5'h00;
    localparam logic [10:0] STATUS_PAD   = 11'h000;
    // Status bit positions
    localparam int ST_T = 4;
    localparam int ST_N = 3;
    localparam int ST_Z = 2;
    localparam int ST_V = 1;
    localparam int ST_C = 0;
    // Pending flag positions, {N, Z, V}
    localparam int PF_N = 2;
    localparam int PF_Z = 1;
    localparam int PF_V = 0;
    localparam logic [2:0]  ZERO_PFLAGS  = 3'h2;
    localparam logic [3:0]  ZERO_NZVC    = 4'h4;
    // Addressing modes
    localparam logic [2:0] M_REG   = 3'h0;
    localparam logic [2:0] M_DEF   = 3'h1;
    localparam logic [2:0] M_AINC  = 3'h2;
    localparam logic [2:0] M_AINCD = 3'h3;
    localparam logic [2:0] M_ADEC  = 3'h4;
    localparam logic [2:0] M_ADECD = 3'h5;
    localparam logic [2:0] M_IDX   = 3'h6;
    localparam logic [2:0] M_IDXD  = 3'h7;

    typedef enum logic [1:0] {CLS_EXEC, CLS_TRAP, CLS_RSVD} cls_t;
    typedef enum logic [1:0] {OP_ZERO, OP_MINUS, OP_IRET, OP_OTHER} op_t;

    typedef struct packed {
        cls_t        cls;
        op_t         op;
        logic        is_byte;
        logic [3:0]  op4;
        logic [5:0]  src;
        logic [6:0]  op7;
        logic [2:0]  reg_no;
        logic [5:0]  disp6;
        logic [7:0]  op8;
        logic [7:0]  disp8;
        logic [9:0]  op10;
        logic [5:0]  spec;
        logic [2:0]  low_reg;
    } decode_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic        byte_acc;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mem_cmd_t;
endpackage

//--- opcode_classifier.sv
// Opcode classifier: splits a 16-bit word into formats and its class.
// Purely combinational; the caller registers the instruction word.
module opcode_classifier (
    input  wire logic [15:0]        instr,
    output compat_pkg::decode_t     info
);
    import compat_pkg::*;
    logic       d5;
    logic [2:0] d4;
    logic [2:0] d3;
    logic [2:0] d2;
    logic [2:0] d1;
    logic [2:0] d0;

    // Octal digits of the word, most significant first
    assign d5 = instr[15];
    assign d4 = instr[14:12];
    assign d3 = instr[11:9];
    assign d2 = instr[8:6];
    assign d1 = instr[5:3];
    assign d0 = instr[2:0];

    // Anything not matched below stays reserved
    always_comb begin
        info         = '0;
        info.cls     = CLS_RSVD;
        info.op      = OP_OTHER;
        info.op4     = instr[15:12];
        info.src     = instr[11:6];
        info.op7     = instr[15:9];
        info.reg_no  = instr[8:6];
        info.disp6   = instr[5:0];
        info.op8     = instr[15:8];
        info.disp8   = instr[7:0];
        info.op10    = instr[15:6];
        info.spec    = instr[5:0];
        info.low_reg = instr[2:0];
        if (d4 == 3'h7) begin
            // Multiply to exclusive-or and loop; 17xxxx floating point stays reserved
            if (!d5 && (d3 <= 3'h4 || d3 == 3'h7)) info.cls = CLS_EXEC;
        end else if (d4 != 3'h0) begin
            info.cls     = CLS_EXEC;
            info.is_byte = d5 && (d4 != 3'h6);
        end else begin
            unique case (d3)
                3'h0: begin
                    if (d5) info.cls = CLS_EXEC;
                    else if (d2 == 3'h0) begin
                        if (d1 == 3'h0 && (d0 == 3'h2 || d0 == 3'h6)) begin
                            info.cls = CLS_EXEC;
                            info.op  = OP_IRET;
                        end else if (d1 == 3'h0 && (d0 == 3'h3 || d0 == 3'h4)) info.cls = CLS_TRAP;
                    end else if (d2 == 3'h2) begin
                        if (d1 == 3'h0 || d1 >= 3'h4) info.cls = CLS_EXEC;
                    end else info.cls = CLS_EXEC;
                end
                3'h1, 3'h2, 3'h3: info.cls = CLS_EXEC;
                3'h4: info.cls = d5 ? CLS_TRAP : CLS_EXEC;
                3'h5: begin
                    info.cls     = CLS_EXEC;
                    info.is_byte = d5;
                    if (d2 == 3'h0) info.op = OP_ZERO;
                    if (d2 == 3'h3) info.op = OP_MINUS;
                end
                3'h6: begin
                    // Previous-space moves run as plain current-stack pushes and pops
                    if (d2 != 3'h4 && !(d5 && d2 == 3'h7)) info.cls = CLS_EXEC;
                    info.is_byte = d5 && (d2 <= 3'h3);
                end
                3'h7: info.cls = CLS_RSVD;
            endcase
        end
    end
endmodule

//--- flag_alu.sv
// Clear and decrement datapath with its N, Z, V flags at one width.
// Combinational; instantiated once per operand width.
module flag_alu #(
    parameter int W = 16
) (
    input  wire logic [W-1:0] opnd,
    input  wire logic         clear,
    output logic [W-1:0]      result,
    output logic              neg,
    output logic              zero,
    output logic              ovf
);
    localparam logic [W-1:0] ONE     = W'(1);
    localparam logic [W-1:0] MOST_NEG = {1'b1, {(W-1){1'b0}}};

    // Wraparound subtraction gives the largest positive from the most negative
    always_comb begin
        result = clear ? '0 : opnd - ONE;
        neg    = result[W-1];
        zero   = (result == '0);
        ovf    = !clear && (opnd == MOST_NEG);
    end
endmodule

//--- mem_model.sv
// Operand memory partner: a small word array behind a req/ack handshake.
// Assumes the unit holds req and its qualifiers until the acked edge.
module mem_model (
    input  wire logic            mclk,
    input  compat_pkg::mem_cmd_t cmd,
    input  wire logic            stall,
    output logic                 ack,
    output logic [15:0]          rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import compat_pkg::*;
    logic [15:0] mem [0:255];
    logic [15:0] last_rd = 16'h0000;
    // Stall on alternate cycles so prompt and slow answers both occur
    assign ack = cmd.req && !stall;
    // Off an acked read the lines show the inverse of the last word, never a stale copy
    assign rdata = (ack && !cmd.we) ? mem[cmd.addr[8:1]] : ~last_rd;
    always @(posedge mclk) begin
        if (ack && cmd.we) mem[cmd.addr[8:1]] <= cmd.wdata;
        if (ack && !cmd.we) last_rd <= mem[cmd.addr[8:1]];
    end
endmodule

//--- testbench.sv
// Self-checking bench for the compatibility decode unit and its memory partner.
// Assumes every design input changes on the rising edge of mclk.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import compat_pkg::*;
    logic        mclk = 0, rst = 1, run = 0, ext_done = 0, fault_ack = 0, status_load = 0, reg_wr = 0, stall = 0;
    logic [4:0]  status_in = 5'h00;
    logic [2:0]  reg_idx = 3'h0, c;
    logic [15:0] reg_wdata = 16'h0000, mem_rdata, fault_instr, compat_status_word, reg_rdata, v;
    logic        mem_ack, class_exec, class_trap, class_rsvd, exec_other, fault, fault_is_trap, busy;
    mem_cmd_t    mem_cmd;
    decode_t     decode_info;
    int          err_count = 0, cmp_count = 0;
    logic [15:0] wl [12] = '{16'h0003, 16'h0004, 16'h8800, 16'h89ff, 16'h0000, 16'hf000,
                            16'h7c00, 16'h0e00, 16'h0088, 16'h00a0, 16'h7e41, 16'h1083};
    logic [2:0]  cl [12] = '{3'h2, 3'h2, 3'h2, 3'h2, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h4, 3'h4, 3'h4};
    always #2 mclk = ~mclk;
    always @(posedge mclk) stall <= ~stall;
    mem_model mem_model_i (.mclk(mclk), .cmd(mem_cmd), .stall(stall), .ack(mem_ack), .rdata(mem_rdata));
    compat_mode_decode_unit compat_mode_decode_unit_i (.mclk, .rst, .run, .mem_cmd, .mem_ack, .mem_rdata,
        .class_exec, .class_trap, .class_rsvd, .decode_info, .exec_other, .ext_done, .fault, .fault_is_trap,
        .fault_instr, .fault_ack, .status_load, .status_in, .compat_status_word, .reg_wr, .reg_idx,
        .reg_wdata, .reg_rdata, .busy);
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // Register or status load; only taken while stopped
    task automatic load(input logic k, input logic [2:0] i, input logic [15:0] d);
        @(posedge mclk);
        reg_wr <= !k;
        status_load <= k;
        reg_idx <= i;
        reg_wdata <= d;
        status_in <= d[4:0];
        @(posedge mclk);
        reg_wr <= 1'b0;
        status_load <= 1'b0;
        #1;
    endtask
    task automatic rdreg(input logic [2:0] i);
        @(posedge mclk) reg_idx <= i;
        repeat (2) @(posedge mclk);
        #1 v = reg_rdata;
    endtask
    // One instruction: run for a cycle, answer faults and hand-offs, wait for idle
    task automatic step(input logic [15:0] pc, input logic [15:0] w);
        logic f, x;
        f = 0;
        x = 0;
        c = 3'h0;
        mem_model_i.mem[pc[8:1]] = w;
        load(1'b0, PC_IDX, pc);
        @(posedge mclk) run <= 1'b1;
        @(posedge mclk) run <= 1'b0;
        #1;
        for (int n = 0; n < 99 && busy !== 1'b0; n++) begin
            @(posedge mclk);
            fault_ack <= f;
            ext_done <= x;
            #1 c = c | {class_exec, class_trap, class_rsvd};
            f = (fault === 1'b1) && (fault_ack !== 1'b1);
            x = (exec_other === 1'b1) && (ext_done !== 1'b1);
            if (f) chk("fault_instr", w, fault_instr);
            if (f) chk("fault_kind", {15'h0, c[1]}, {15'h0, fault_is_trap});
        end
        chk("idle", 16'h0000, {15'h0, busy});
        @(posedge mclk) fault_ack <= 1'b0;
        ext_done <= 1'b0;
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 12; i++) begin
            step(16'h0080, wl[i]);
            chk("class", {13'h0, cl[i]}, {13'h0, c});
            chk("fmt_two", wl[i], {decode_info.op4, decode_info.src, decode_info.spec});
            chk("fmt_loop", wl[i], {decode_info.op7, decode_info.reg_no, decode_info.disp6});
            chk("fmt_branch", wl[i], {decode_info.op8, decode_info.disp8});
        end
        $display("test classes done");
        load(1'b1, 3'h0, 16'h001f);
        chk("status", 16'h001f, compat_status_word);
        mem_model_i.mem[8'h09] = 16'h0020;
        mem_model_i.mem[8'h1a] = 16'hbeef;
        step(16'h0010, 16'h0a37);
        chk("zero_dst", 16'h0000, mem_model_i.mem[8'h1a]);
        chk("zero_status", 16'h0014, compat_status_word);
        $display("test clear done");
        load(1'b0, 3'h1, 16'h0040);
        load(1'b1, 3'h0, 16'h0001);
        mem_model_i.mem[8'h1f] = 16'h0050;
        mem_model_i.mem[8'h28] = 16'h8000;
        step(16'h0020, 16'h0ae9);
        chk("minus_dst", 16'h7fff, mem_model_i.mem[8'h28]);
        chk("minus_status", 16'h0003, compat_status_word);
        rdreg(3'h1);
        chk("minus_reg", 16'h003e, v);
        $display("test decrement done");
        load(1'b0, SP_IDX, 16'h0100);
        mem_model_i.mem[8'h80] = 16'h0200;
        mem_model_i.mem[8'h81] = 16'hffea;
        step(16'h0030, 16'h0002);
        chk("iret_status", 16'h000a, compat_status_word);
        rdreg(PC_IDX);
        chk("iret_pc", 16'h0200, v);
        $display("test return done");
        // Index on a plain register, then a byte decrement held in a register
        load(1'b0, 3'h2, 16'h1280);
        mem_model_i.mem[8'h21] = 16'h0010;
        mem_model_i.mem[8'h27] = 16'h1234;
        step(16'h0040, 16'h0a31);
        chk("zero_idx_dst", 16'h0000, mem_model_i.mem[8'h27]);
        chk("zero_idx_status", 16'h0004, compat_status_word);
        step(16'h0060, 16'h8ac2);
        chk("minus_byte_status", 16'h0002, compat_status_word);
        rdreg(3'h2);
        chk("minus_byte_reg", 16'h127f, v);
        $display("test index and byte done");
        end_of_test;
    end
    // Watchdog at 10000 cycles, far beyond the few hundred cycles the tests need
    initial begin
        #40000;
        err_count++;
        end_of_test;
    end
endmodule
